// >>> src/bfps_pkg.sv
// Constants and carrier types for the converter fault and power-ok supervisor.
// Assumes a single 40 MHz timing clock and an active-low asynchronous reset.

package bfps_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int QUAL_TIME_NS = 20_000;
    localparam int SS_TIME_NS = 600_000;
    localparam int PG_FILT_NS = 10_000;
    localparam int QUAL_CYCLES = QUAL_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int SS_CYCLES = SS_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int PG_CYCLES = PG_FILT_NS / (1_000_000_000 / CLK_HZ);
    localparam int REF_WIDTH = 10;
    localparam logic [9:0] REF_FINAL = 10'h3FF;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ov_cmp;       // Output above over-voltage trip
        logic uv_cmp;       // Output below under-voltage trip
        logic above_reg;    // Output above regulation level
        logic lockout_fall; // Input fell below lockout-falling level
        logic lockout_rise; // Input above lockout-rising level
        logic over_temp;    // Junction above 150 C
        logic pg_low_cmp;   // Output 15 percent below set value
        logic pg_ok_cmp;    // Output at or above 90 percent
        logic zero_cur;     // Inductor current at zero
        logic ontime_req;   // On-time pulse request
    } bfps_sense_t;

    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } bfps_gate_t;

    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_SOFT = 4'b0010,
        ST_RUN = 4'b0100,
        ST_LATCH = 4'b1000
    } bfps_state_t;

endpackage : bfps_pkg

// >>> src/bfps_qual.sv
// Continuous-assertion qualifier: output goes high after input held high N cycles.
// Assumes input already synchronous to clk.
`timescale 1ns/100ps
module bfps_qual #(
    parameter int CYCLES = 800
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic din,
    output logic qualified
);
    logic [$clog2(CYCLES+1)-1:0] cnt;

    // ------------------------------------------------------------------
    // Counter resets on any drop, so only continuous assertion counts
    // ------------------------------------------------------------------
    // counter qualifier
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            qualified <= 1'b0;
        end else if (!din) begin
            cnt <= '0;
            qualified <= 1'b0;
        end else if (cnt == $bits(cnt)'(CYCLES - 1)) begin
            qualified <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    AST_QUAL_NEEDS_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        $rose(qualified) |-> $past(din))
        else $error("qualified rose without input held");
endmodule : bfps_qual

// >>> src/bfps_top.sv
// Supervisor for a step-down converter: fault latching, lockout, soft-start, power-ok.
// Comparator inputs and enable arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
module bfps_top #(
    parameter int QUAL_N = bfps_pkg::QUAL_CYCLES,
    parameter int SS_N = bfps_pkg::SS_CYCLES,
    parameter int PG_N = bfps_pkg::PG_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable_in,
    input wire logic peak_limit,
    input wire bfps_pkg::bfps_sense_t sense,
    output bfps_pkg::bfps_gate_t gate,
    output logic switching_ok,
    output logic aux_linear_regulator_en,
    output logic discharge_en,
    output logic [bfps_pkg::REF_WIDTH-1:0] soft_ref,
    output logic power_ok_out_oe,
    output logic output_overvolt_fault,
    output logic output_undervolt_fault,
    output logic over_temp_fault,
    output logic input_lockout,
    output logic soft_start_active
);
    import bfps_pkg::*;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    bfps_sense_t sense_m, s;
    logic en_m, en_s, pk_m, pk_s, en_prev;

    // Two stages for every asynchronous input
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sense_m <= '0;
            s <= '0;
            en_m <= 1'b0;
            en_s <= 1'b0;
            pk_m <= 1'b0;
            pk_s <= 1'b0;
        end else begin
            sense_m <= sense;
            s <= sense_m;
            en_m <= enable_in;
            en_s <= en_m;
            pk_m <= peak_limit;
            pk_s <= pk_m;
        end
    end

    // Enable history for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_prev <= 1'b0;
        end else begin
            en_prev <= en_s;
        end
    end

    // ------------------------------------------------------------------
    // Fault qualification
    // ------------------------------------------------------------------
    logic ov_q, uv_q, pk_uv;

    bfps_qual #(.CYCLES(QUAL_N)) u_ov (
        .clk(clk),
        .nrst(nrst),
        .din(s.ov_cmp),
        .qualified(ov_q)
    );

    bfps_qual #(.CYCLES(QUAL_N)) u_uv (
        .clk(clk),
        .nrst(nrst),
        .din(s.uv_cmp),
        .qualified(uv_q)
    );

    // Peak limit held while output under-voltage; same qualification applies
    // peak then undervolt
    assign pk_uv = pk_s & uv_q;

    // ------------------------------------------------------------------
    // Input lockout, hysteretic and not latched
    // ------------------------------------------------------------------
    // lockout hysteresis
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            input_lockout <= 1'b1;
        end else if (s.lockout_fall) begin
            input_lockout <= 1'b1;
        end else if (s.lockout_rise) begin
            input_lockout <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Latched faults
    // ------------------------------------------------------------------
    // Over-voltage arms whenever enabled out of lockout, under-voltage only in run unless peak limit, so soft-start undershoot is ignored;
    // enable low wipes them, a power cycle resets them through nrst.
    bfps_state_t state;
    logic armed;
    assign armed = en_s & ~input_lockout;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            output_overvolt_fault <= 1'b0;
            output_undervolt_fault <= 1'b0;
        end else if (!en_s) begin
            output_overvolt_fault <= 1'b0;
            output_undervolt_fault <= 1'b0;
        end else if (armed) begin
            if (ov_q) begin
                output_overvolt_fault <= 1'b1;
            end
            if ((uv_q && state == ST_RUN) || pk_uv) begin
                output_undervolt_fault <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            over_temp_fault <= 1'b0;
        end else if (!en_s) begin
            over_temp_fault <= 1'b0;
        end else if (s.over_temp) begin
            over_temp_fault <= 1'b1;
        end
    end

    logic any_fault;
    assign any_fault = output_overvolt_fault | output_undervolt_fault | over_temp_fault;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic [$clog2(SS_N+1)-1:0] ss_cnt;
    logic restart;
    assign restart = en_s & ~en_prev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_OFF;
        end else begin
            case (state)
                ST_OFF: begin
                    if (en_s && !input_lockout) begin
                        state <= ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (!en_s || input_lockout) begin
                        state <= ST_OFF;
                    end else if (any_fault) begin
                        state <= ST_LATCH;
                    end else if (ss_cnt == $bits(ss_cnt)'(SS_N - 1)) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!en_s || input_lockout) begin
                        state <= ST_OFF;
                    end else if (any_fault) begin
                        state <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    if (!en_s) begin
                        state <= ST_OFF;
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // Soft-start timer; reference ramps with it instead of stepping
    // reference ramp
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ss_cnt <= '0;
            soft_ref <= '0;
        end else if (state == ST_SOFT) begin
            ss_cnt <= ss_cnt + 1'b1;
            soft_ref <= REF_WIDTH'((32'(ss_cnt) * 32'(REF_FINAL)) / SS_N);
        end else if (state == ST_RUN) begin
            soft_ref <= REF_FINAL;
        end else begin
            ss_cnt <= '0;
            soft_ref <= '0;
        end
    end

    // Soft-start indication, registered like every other output
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            soft_start_active <= 1'b0;
        end else begin
            soft_start_active <= (state == ST_SOFT);
        end
    end

    // ------------------------------------------------------------------
    // Power-stage outputs
    // ------------------------------------------------------------------
    logic run_ok;
    assign run_ok = (state == ST_SOFT || state == ST_RUN) && !any_fault && !input_lockout;

    // output above regulation forces low side until zero current or on-time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate <= '0;
            switching_ok <= 1'b0;
        end else begin
            switching_ok <= run_ok;
            if (!run_ok) begin
                gate <= '0;
            end else if (s.above_reg) begin
                gate.hs_on <= 1'b0;
                gate.ls_on <= ~(s.zero_cur | s.ontime_req);
            end else begin
                gate.hs_on <= s.ontime_req;
                gate.ls_on <= ~s.ontime_req & ~s.zero_cur;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aux_linear_regulator_en <= 1'b0;
            discharge_en <= 1'b1;
        end else begin
            aux_linear_regulator_en <= ~input_lockout;
            discharge_en <= any_fault | ~en_s | input_lockout;
        end
    end

    // ------------------------------------------------------------------
    // Power-ok with hysteresis and filter
    // ------------------------------------------------------------------
    logic pg_target, pg_state;
    logic [$clog2(PG_N+1)-1:0] pg_cnt;

    // drop at 15 percent low, recover at 90 percent
    always_comb begin
        pg_target = pg_state;
        if (s.pg_low_cmp) begin
            pg_target = 1'b0;
        end else if (s.pg_ok_cmp) begin
            pg_target = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pg_state <= 1'b0;
            pg_cnt <= '0;
        end else if (pg_target == pg_state) begin
            pg_cnt <= '0;
        end else if (pg_cnt == $bits(pg_cnt)'(PG_N - 1)) begin
            pg_state <= pg_target;
            pg_cnt <= '0;
        end else begin
            pg_cnt <= pg_cnt + 1'b1;
        end
    end

    // held low unless running; enable drives pin low (open drain)
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            power_ok_out_oe <= 1'b1;
        end else begin
            power_ok_out_oe <= ~(pg_state && state == ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_FAULT_STOPS_GATES: assert property (@(posedge clk) disable iff (!nrst)
        any_fault |=> ##1 (gate == '0))
        else $error("gates active while fault latched");

    AST_FAULT_HELD: assert property (@(posedge clk) disable iff (!nrst)
        (output_overvolt_fault && en_s) |=> output_overvolt_fault)
        else $error("overvoltage fault dropped while enabled");

    AST_ENLOW_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
        !en_s |=> !any_fault)
        else $error("fault not cleared by enable low");

    AST_OT_LATCH: assert property (@(posedge clk) disable iff (!nrst)
        (s.over_temp && en_s) |=> over_temp_fault)
        else $error("over-temperature not latched");

    AST_AUX_REG: assert property (@(posedge clk) disable iff (!nrst)
        !input_lockout |=> aux_linear_regulator_en)
        else $error("aux regulator off above lockout");

    AST_DISCHARGE: assert property (@(posedge clk) disable iff (!nrst)
        (input_lockout || !en_s) |=> discharge_en)
        else $error("discharge not active");

    sequence seq_soft_start;
        state == ST_SOFT;
    endsequence

    AST_PG_LOW_SOFT: assert property (@(posedge clk) disable iff (!nrst)
        seq_soft_start |=> power_ok_out_oe)
        else $error("power-ok released during soft-start");

    AST_LOCKOUT_SET: assert property (@(posedge clk) disable iff (!nrst)
        s.lockout_fall |=> input_lockout ##1 !gate.hs_on)
        else $error("lockout did not inhibit switching");

    AST_REF_FINAL: assert property (@(posedge clk) disable iff (!nrst)
        (state == ST_RUN) |=> (soft_ref == REF_FINAL))
        else $error("reference not at final value in run");

    AST_OV_QUALIFIED: assert property (@(posedge clk) disable iff (!nrst)
        $rose(output_overvolt_fault) |-> $past(ov_q))
        else $error("overvoltage fault set without qualification");

    AST_UV_QUALIFIED: assert property (@(posedge clk) disable iff (!nrst)
        $rose(output_undervolt_fault) |-> $past(uv_q))
        else $error("undervoltage fault set without qualification");

    AST_RESTART_SOFT: assert property (@(posedge clk) disable iff (!nrst)
        (restart && !input_lockout && state == ST_OFF) |=> (state == ST_SOFT))
        else $error("enable rise did not start soft-start");

    AST_PG_FILTERED: assert property (@(posedge clk) disable iff (!nrst)
        $changed(pg_state) |-> ($past(pg_cnt) == PG_N - 1))
        else $error("power-ok changed before filter expired");

endmodule : bfps_top

// >>> test/bfps_plant.sv
// Far-side model for the supervisor: comparators and a crude output-level plant.
// Assumes the bench supplies the raw comparator levels and a droop request.
`timescale 1ns/100ps
module bfps_plant
    import bfps_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic switching_ok,
    input wire logic discharge_en,
    input wire logic droop,
    input wire bfps_pkg::bfps_sense_t raw,
    output bfps_pkg::bfps_sense_t sense
);
    // ------------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------------
    logic [7:0] converter_output;

    // Level in percent of set value: rises while switching, bleeds on discharge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            converter_output <= 8'h00;
        end else if (switching_ok && !discharge_en && converter_output < 8'h64) begin
            converter_output <= converter_output + 8'h01;
        end else if (discharge_en && converter_output > 8'h01) begin
            converter_output <= converter_output - 8'h02;
        end
    end

    // ------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------
    // Droop forces both power-ok comparators, so a load dip needs no real ramp
    always_comb begin
        sense = raw;
        sense.pg_low_cmp = droop || (converter_output < 8'h55);
        sense.pg_ok_cmp = !droop && (converter_output >= 8'h5a);
    end
endmodule : bfps_plant

// >>> test/test_bfps_top.sv
// Self-checking bench for the converter fault and power-ok supervisor.
// Assumes the plant model on the sense bus and shortened counts 8/40/4.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module test_bfps_top;
    import bfps_pkg::*;
    localparam int QN = 8;
    localparam int SN = 40;
    localparam int PN = 4;
    localparam logic [12:0] M_SS = 13'h0001, M_LK = 13'h0002, M_OT = 13'h0004;
    localparam logic [12:0] M_UV = 13'h0008, M_OV = 13'h0010, M_PG = 13'h0020;
    localparam logic [12:0] M_DIS = 13'h0040, M_AUX = 13'h0080, M_SW = 13'h0100;
    localparam logic [12:0] M_LS = 13'h0200, M_HS = 13'h0400, M_FIN = 13'h0800;
    localparam logic [12:0] M_MID = 13'h1000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic enable_in = 1'b0;
    logic peak_limit = 1'b0;
    logic droop = 1'b0;
    bfps_sense_t raw = '0;
    bfps_sense_t sense;
    bfps_gate_t gate;
    logic switching_ok, aux_en, discharge_en, pg_oe, ovf, uvf, otf, lockout, ssa;
    logic [REF_WIDTH-1:0] soft_ref;
    logic [12:0] obs;
    logic [25:0] q[$];
    int failures = 0;
    int n_compared = 0;
    logic [12:0] fm;
    event chk_ev;

    assign obs = {soft_ref != '0 && soft_ref != REF_FINAL, soft_ref == REF_FINAL, gate.hs_on,
        gate.ls_on, switching_ok, aux_en, discharge_en, pg_oe, ovf, uvf, otf, lockout, ssa};

    bfps_top #(.QUAL_N(QN), .SS_N(SN), .PG_N(PN)) u_dut (.clk(clk), .nrst(nrst),
        .enable_in(enable_in), .peak_limit(peak_limit), .sense(sense), .gate(gate),
        .switching_ok(switching_ok), .aux_linear_regulator_en(aux_en),
        .discharge_en(discharge_en), .soft_ref(soft_ref), .power_ok_out_oe(pg_oe),
        .output_overvolt_fault(ovf), .output_undervolt_fault(uvf), .over_temp_fault(otf),
        .input_lockout(lockout), .soft_start_active(ssa));

    bfps_plant u_plant (.clk(clk), .nrst(nrst), .switching_ok(switching_ok),
        .discharge_en(discharge_en), .droop(droop), .raw(raw), .sense(sense));

    // ------------------------------------------------------------------
    // Clock, watcher and watchdog
    // ------------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Oldest note against the outputs of the moment it was posted
    initial begin : watch
        logic [25:0] n;
        forever begin
            @(chk_ev);
            // Drain every note posted in this time step
            while (q.size() > 0) begin
                n = q.pop_front();
                `CHK(obs & n[25:13], n[12:0])
            end
        end
    end

    // Whole run is under 1500 cycles; this limit is 30000 cycles, over twenty times that
    initial begin
        #(25 * 30000);
        failures++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic note(input logic [12:0] mask, input logic [12:0] val);
        q.push_back({mask, val});
        -> chk_ev;
    endtask : note

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wait_for(input logic [12:0] mask, input logic [12:0] val, input int max);
        for (int i = 0; i < max && (obs & mask) !== val; i++) begin
            @(negedge clk);
        end
    endtask : wait_for

    task automatic set_cmp(input int k, input logic v);
        case (k)
            0: raw.ov_cmp = v;
            1: raw.uv_cmp = v;
            default: raw.over_temp = v;
        endcase
    endtask : set_cmp

    // Enable rise, soft-start length and ramp, then power-ok release
    task automatic run_up();
        enable_in = 1'b1;
        wait_for(M_SS, M_SS, 10);
        note(M_SS | M_PG | M_FIN, M_SS | M_PG);
        cyc(SN / 2);
        note(M_MID | M_PG, M_MID | M_PG);
        cyc(SN / 2 - 4);
        note(M_SS | M_PG, M_SS | M_PG);
        wait_for(M_SS, 13'h0000, 12);
        note(M_SS | M_FIN | M_SW, M_FIN | M_SW);
        wait_for(M_PG, 13'h0000, 200);
        note(M_PG | M_SW, M_SW);
    endtask : run_up

    task automatic drop_en();
        enable_in = 1'b0;
        cyc(6);
        note(M_OV | M_UV | M_OT | M_SW | M_DIS | M_AUX | M_HS, M_DIS | M_AUX);
    endtask : drop_en

    task automatic test_done();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin : main
        void'($urandom(25660));
        raw.lockout_rise = 1'b1;
        cyc(12);
        note(13'h1f7f, M_LK | M_DIS | M_PG);
        nrst = 1'b1;
        wait_for(M_LK, 13'h0000, 10);
        cyc(1); // Aux enable follows the lockout flag one clock later
        note(M_LK | M_AUX | M_SW, M_AUX);
        $display("test reset done");
        run_up();
        $display("test start-up done");
        for (int k = 0; k < 3; k++) begin
            fm = M_OT << (2 - k);
            if (k < 2) begin
                set_cmp(k, 1'b1);
                cyc($urandom % (QN - 3) + 1);
                set_cmp(k, 1'b0);
                cyc(QN + 4);
                note(fm | M_SW, M_SW);
            end
            set_cmp(k, 1'b1);
            cyc(QN + 8);
            note(fm | M_SW | M_HS | M_LS | M_DIS, fm | M_DIS);
            set_cmp(k, 1'b0);
            cyc(6);
            note(fm | M_SW, fm);
            drop_en();
            run_up();
        end
        $display("test faults done");
        droop = 1'b1;
        cyc($urandom % (PN - 2) + 1);
        droop = 1'b0;
        cyc(3); // An unfiltered drop would still show here
        note(M_PG, 13'h0000);
        cyc(PN + 1);
        note(M_PG, 13'h0000);
        droop = 1'b1;
        cyc(PN + 8);
        note(M_PG | M_SW | M_UV, M_PG | M_SW);
        droop = 1'b0;
        cyc(PN + 8);
        note(M_PG, 13'h0000);
        $display("test power-ok done");
        raw.above_reg = 1'b1;
        cyc(5);
        note(M_HS | M_LS | M_SW, M_LS | M_SW);
        raw.ontime_req = 1'b1;
        cyc(5);
        note(M_HS | M_LS, 13'h0000);
        raw.ontime_req = 1'b0;
        raw.zero_cur = 1'b1;
        cyc(5);
        note(M_HS | M_LS, 13'h0000);
        raw.above_reg = 1'b0;
        raw.zero_cur = 1'b0;
        raw.ontime_req = 1'b1;
        cyc(5);
        note(M_HS | M_LS | M_SW, M_HS | M_SW);
        raw.ontime_req = 1'b0;
        $display("test above-regulation done");
        raw.lockout_fall = 1'b1;
        raw.lockout_rise = 1'b0;
        cyc(6);
        note(M_LK | M_SW | M_DIS | M_AUX | M_HS | M_LS, M_LK | M_DIS);
        raw.lockout_fall = 1'b0;
        cyc(6);
        note(M_LK | M_SW, M_LK);
        raw.lockout_rise = 1'b1;
        wait_for(M_SW, M_SW, SN + 20);
        note(M_LK | M_SW | M_OV | M_UV | M_OT, M_SW);
        drop_en();
        $display("test lockout done");
        enable_in = 1'b1;
        wait_for(M_SS, M_SS, 10);
        raw.uv_cmp = 1'b1;
        cyc(QN + 4);
        note(M_UV | M_SS, M_SS);
        peak_limit = 1'b1;
        cyc(QN + 8);
        note(M_UV | M_SW | M_DIS, M_UV | M_DIS);
        raw.uv_cmp = 1'b0;
        peak_limit = 1'b0;
        drop_en();
        $display("test peak-limit done");
        test_done();
    end
endmodule : test_bfps_top
